/* src/config_loader.sv */
// Our own choices: the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module config_loader (
	input wire logic clk,
	input wire logic rstn,
	cfg_prom_if.loader link,
	input wire logic start,
	input wire logic parallel_mode,
	input wire logic [cfg_prom_pkg::CNT_W-1:0] location_count,
	input wire logic hold_req,
	output logic [cfg_prom_pkg::DATA_W-1:0] rx_data,
	output logic rx_valid,
	output logic loading,
	output logic done
);

	cfg_prom_pkg::load_state_t state;
	logic [cfg_prom_pkg::PHASE_W-1:0] phase;
	logic [cfg_prom_pkg::CNT_W-1:0] taken;
	logic [cfg_prom_pkg::DATA_W-1:0] shift;
	logic [cfg_prom_pkg::BIT_SEL_W-1:0] bit_cnt;
	logic clock_q;
	logic busy_q;
	logic half_end;
	logic rise_now;
	logic fall_now;
	logic capture;
	logic last_taken;

	assign half_end = phase == cfg_prom_pkg::HALF_LAST;
	assign rise_now = state == cfg_prom_pkg::ST_RUN && half_end && !clock_q;
	assign fall_now = state == cfg_prom_pkg::ST_RUN && half_end && clock_q;
	assign capture = rise_now && !busy_q;
	assign last_taken = taken == location_count;

	// sequence: reset pulse, clocking, then release the memory
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= cfg_prom_pkg::ST_IDLE;
			phase <= cfg_prom_pkg::PHASE_RST;
		end else begin
			case (state)
				cfg_prom_pkg::ST_IDLE, cfg_prom_pkg::ST_DONE: begin
					phase <= cfg_prom_pkg::PHASE_RST;
					if (start) begin
						state <= cfg_prom_pkg::ST_INIT;
					end
				end
				cfg_prom_pkg::ST_INIT: begin
					phase <= phase + 4'h1;
					if (phase == cfg_prom_pkg::INIT_LAST) begin
						phase <= cfg_prom_pkg::PHASE_RST;
						state <= cfg_prom_pkg::ST_RUN;
					end
				end
				cfg_prom_pkg::ST_RUN: begin
					phase <= half_end ? cfg_prom_pkg::PHASE_RST : phase + 4'h1;
					// finish on a falling edge once all locations are in
					if (fall_now && last_taken) begin
						state <= cfg_prom_pkg::ST_DONE;
					end
				end
				default: begin
					state <= cfg_prom_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// clock at no more than the fastest rate, equal halves
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clock_q <= 1'b0;
		end else if (state != cfg_prom_pkg::ST_RUN) begin
			clock_q <= 1'b0;
		end else if (half_end) begin
			clock_q <= ~clock_q;
		end
	end

	// busy changes only at the fall, stable across the next rise
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
		end else if (state != cfg_prom_pkg::ST_RUN) begin
			busy_q <= 1'b0;
		end else if (fall_now) begin
			busy_q <= hold_req;
		end
	end

	// data shown after the last rise is taken at this rise
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			taken <= cfg_prom_pkg::CNT_RST;
			shift <= cfg_prom_pkg::DATA_RST;
			bit_cnt <= 3'h0;
			rx_data <= cfg_prom_pkg::DATA_RST;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (state == cfg_prom_pkg::ST_INIT) begin
				taken <= cfg_prom_pkg::CNT_RST;
				bit_cnt <= 3'h0;
			end else if (capture && !last_taken) begin
				taken <= taken + 11'h001;
				if (parallel_mode) begin
					rx_data <= link.data_line;
					rx_valid <= 1'b1;
				end else begin
					// serial bits gather most significant first
					shift <= {shift[6:0], link.data_line[0]};
					bit_cnt <= bit_cnt + 3'h1;
					if (bit_cnt == 3'h7) begin
						rx_data <= {shift[6:0], link.data_line[0]};
						rx_valid <= 1'b1;
					end
				end
			end
		end
	end

	assign link.config_clock = clock_q;
	// active-low reset from the startup phase, as the memory expects
	assign link.reset_gate = state != cfg_prom_pkg::ST_INIT;
	assign link.chip_select_n = state == cfg_prom_pkg::ST_IDLE ||
		state == cfg_prom_pkg::ST_DONE;
	assign link.busy = busy_q;
	assign link.busy_oe = 1'b1;
	assign loading = state == cfg_prom_pkg::ST_INIT ||
		state == cfg_prom_pkg::ST_RUN;
	assign done = state == cfg_prom_pkg::ST_DONE;

endmodule
`default_nettype wire

/* src/cfg_prom_pkg.sv */
`default_nettype none
package cfg_prom_pkg;
	// link and memory shape
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 256;
	localparam int ADDR_W = 8;
	// a location counter wide enough to count single bits of the array
	localparam int BIT_SEL_W = 3;
	localparam int CNT_W = ADDR_W + BIT_SEL_W;
	localparam logic [CNT_W-1:0] CNT_RST = 11'h000;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [DATA_W-1:0] ALL_LANES = 8'hFF;
	localparam logic [DATA_W-1:0] SERIAL_LANE = 8'h01;
	localparam int SERIAL_LANE_POS = 0;

	// timing: system clock and fastest configuration clock
	localparam int SYS_CLK_MHZ = 100;
	localparam int SYS_CLK_NS = 1000 / SYS_CLK_MHZ;
	localparam int CFG_CLK_MAX_MHZ = 20;
	localparam int CFG_CLK_MIN_NS = 1000 / CFG_CLK_MAX_MHZ;
	// least half period, rounded up to whole system cycles
	localparam int HALF_CYCLES_INT =
		(CFG_CLK_MIN_NS / 2 + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int PHASE_W = 4;
	localparam logic [PHASE_W-1:0] HALF_LAST = 4'(HALF_CYCLES_INT - 1);
	// least time the loader holds the memory in reset before a load
	localparam int INIT_NS = 100;
	localparam int INIT_CYCLES_INT = (INIT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam logic [PHASE_W-1:0] INIT_LAST = 4'(INIT_CYCLES_INT - 1);
	localparam logic [PHASE_W-1:0] PHASE_RST = 4'h0;

	// loader states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_INIT = 2'b01,
		ST_RUN = 2'b10,
		ST_DONE = 2'b11
	} load_state_t;
endpackage
`default_nettype wire

/* src/cfg_prom_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface cfg_prom_if;
	// driven by the configuring logic device
	logic config_clock;
	logic chip_select_n;
	logic reset_gate;
	logic busy;
	logic busy_oe;
	// driven by the memory
	logic [cfg_prom_pkg::DATA_W-1:0] data_out;
	logic [cfg_prom_pkg::DATA_W-1:0] data_oe;
	logic chain_select_out_n;
	// resolved data wires; an undriven lane reads low
	logic [cfg_prom_pkg::DATA_W-1:0] data_line;
	assign data_line = data_out & data_oe;

	modport prom (
		input config_clock,
		input chip_select_n,
		input reset_gate,
		input busy,
		input busy_oe,
		output data_out,
		output data_oe,
		output chain_select_out_n
	);

	modport loader (
		output config_clock,
		output chip_select_n,
		output reset_gate,
		output busy,
		output busy_oe,
		input data_line,
		input chain_select_out_n
	);
endinterface
`default_nettype wire

/* src/config_prom_read_port.sv */
// Notes on behaviour
// - drive word only when selected, gated, before end
// - small variant has one serial output
// - large variant holds serial or parallel mode
// - serial mode enables only lowest data lane
// - serial mode keeps lanes one to seven off
// - parallel mode drives full byte per location
// - count on rising clock when enabled, not busy
// - busy honoured only on large variant
// - reset/gate input polarity is programmable
// - unprogrammed polarity is active high reset
// - reset holds counter zero, outputs released
// - chip select high clears counter, standby
// - chain select low after passing terminal count
// - chain select high once gate or select drop
// - busy freezes counter and present data
// - optional internal pull-down on busy input
// - cascade: chain select feeds next, shared lines
// - logic device clocks, then disables memory
// - new data after rise, captured next rise
// - configuration clock up to 20 MHz
// - parallel gives byte per cycle, serial bit
// - startup status drives every reset/gate input
`timescale 1ns/1ns
`default_nettype none
module config_prom_read_port (
	input wire logic clk,
	input wire logic rstn,
	cfg_prom_if.prom link,
	// programming side: array contents and option straps
	input wire logic prog_we,
	input wire logic [cfg_prom_pkg::ADDR_W-1:0] prog_addr,
	input wire logic [cfg_prom_pkg::DATA_W-1:0] prog_wdata,
	input wire logic wide_variant,
	input wire logic parallel_mode,
	input wire logic reset_active_low,
	input wire logic busy_pulldown,
	input wire logic [cfg_prom_pkg::CNT_W-1:0] terminal_count,
	// status
	output logic standby,
	output logic past_end
);

	logic [cfg_prom_pkg::DATA_W-1:0] mem [cfg_prom_pkg::MEM_DEPTH];
	logic [cfg_prom_pkg::CNT_W-1:0] location;
	logic [cfg_prom_pkg::CNT_W-1:0] next_location;
	logic [cfg_prom_pkg::DATA_W-1:0] data_word;
	logic [cfg_prom_pkg::DATA_W-1:0] next_word;
	logic [cfg_prom_pkg::ADDR_W-1:0] byte_addr;
	logic [cfg_prom_pkg::DATA_W-1:0] read_byte;
	logic clock_prev;
	logic clock_rise;
	logic gate_active;
	logic select_active;
	logic busy_level;
	logic busy_hold;
	logic byte_wide;
	logic enabled;
	logic drive;
	logic advance;
	logic clear_n;

	// polarity of the combined input; a zero strap is active-high reset
	assign gate_active = reset_active_low ? link.reset_gate :
		~link.reset_gate;
	assign select_active = ~link.chip_select_n;
	assign enabled = select_active & gate_active;

	// only byte-capable parts carry the mode strap
	assign byte_wide = wide_variant & parallel_mode;

	// undriven busy reads low only with the pull-down strap set;
	// otherwise it is taken as high, which stalls rather than races
	assign busy_level = link.busy_oe ? link.busy : ~busy_pulldown;
	assign busy_hold = wide_variant & busy_level;

	// async clear from reset or deselect, as well as system reset
	assign clear_n = rstn & enabled;

	// the config clock is sampled as a plain synchronous input
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clock_prev <= 1'b0;
		end else begin
			clock_prev <= link.config_clock;
		end
	end
	assign clock_rise = link.config_clock & ~clock_prev;

	// counting needs select, gate, not past end and no busy
	assign advance = clock_rise & enabled & ~past_end &
		~busy_hold;
	assign next_location = location + 11'h001;

	// address counter, held at zero while reset or deselected
	always_ff @(posedge clk or negedge clear_n) begin
		if (!clear_n) begin
			location <= cfg_prom_pkg::CNT_RST;
		end else if (advance) begin
			location <= next_location;
		end
	end

	// sticky flag set on the step beyond the last location
	always_ff @(posedge clk or negedge clear_n) begin
		if (!clear_n) begin
			past_end <= 1'b0;
		end else if (advance && location == terminal_count) begin
			past_end <= 1'b1;
		end
	end

	// in serial mode a location is one bit, most significant first
	assign byte_addr = byte_wide ? location[cfg_prom_pkg::ADDR_W-1:0] :
		location[cfg_prom_pkg::CNT_W-1:cfg_prom_pkg::BIT_SEL_W];
	assign read_byte = mem[byte_addr];

	// word for the present location, one byte or one bit
	always_comb begin
		next_word = cfg_prom_pkg::DATA_RST;
		if (byte_wide) begin
			next_word = read_byte;
		end else begin
			next_word[cfg_prom_pkg::SERIAL_LANE_POS] =
				read_byte[~location[cfg_prom_pkg::BIT_SEL_W-1:0]];
		end
	end

	// output word register; it follows the counter, so a held
	// counter keeps the data steady
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_word <= cfg_prom_pkg::DATA_RST;
		end else begin
			data_word <= next_word;
		end
	end
	assign link.data_out = data_word;

	// array load from the programming side; no reset on storage
	always_ff @(posedge clk) begin
		if (prog_we) begin
			mem[prog_addr] <= prog_wdata;
		end
	end

	// lanes are released whenever select, gate or count forbid
	assign drive = enabled & ~past_end;

	// per-lane enables: lane zero in serial mode, all in parallel
	genvar lane;
	generate
		for (lane = 0; lane < cfg_prom_pkg::DATA_W; lane++) begin : g_lane
			if (lane == cfg_prom_pkg::SERIAL_LANE_POS) begin : g_first
				assign link.data_oe[lane] = drive;
			end else begin : g_rest
				assign link.data_oe[lane] = drive & byte_wide;
			end
		end
	endgenerate

	// chain select follows inputs at once, no clock needed
	assign link.chain_select_out_n = ~(enabled & past_end);

	// standby shows the deselected low-current state
	assign standby = link.chip_select_n;

endmodule
`default_nettype wire

/* verification/cfg_link_props.sv */
`timescale 1ns/1ns
`default_nettype none
module cfg_link_props (
	input wire logic clk,
	input wire logic rstn,
	input wire logic config_clock,
	input wire logic chip_select_n,
	input wire logic reset_gate,
	input wire logic busy,
	input wire logic [cfg_prom_pkg::DATA_W-1:0] data_out,
	input wire logic [cfg_prom_pkg::DATA_W-1:0] data_oe,
	input wire logic chain_select_out_n
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// released lanes and chain high whenever deselected or gated off
	property p_desel;
		chip_select_n |-> data_oe == 8'h00 && chain_select_out_n;
	endproperty
	a_desel: assert property (p_desel) else $error("lanes on while off");
	property p_gate;
		!reset_gate |-> data_oe == 8'h00 && chain_select_out_n;
	endproperty
	a_gate: assert property (p_gate) else $error("lanes on in reset");
	property p_lanes;
		data_oe inside {8'h00, 8'h01, 8'hFF};
	endproperty
	a_lanes: assert property (p_lanes) else $error("odd lane set");
	property p_end;
		!chain_select_out_n |-> data_oe == 8'h00;
	endproperty
	a_end: assert property (p_end) else $error("driving past end");
	property p_busy;
		busy && $past(busy) && !chip_select_n |-> $stable(data_out);
	endproperty
	a_busy: assert property (p_busy) else $error("data moved on hold");
	// a word only moves just after a clock rise while the link is live
	property p_step;
		$changed(data_out) && !chip_select_n && reset_gate
			&& $past(reset_gate) && !$past(chip_select_n)
			|-> $past(config_clock);
	endproperty
	a_step: assert property (p_step) else $error("step without clock");
	property p_fall;
		$fell(chain_select_out_n) |-> $past(config_clock);
	endproperty
	a_fall: assert property (p_fall) else $error("chain fell early");
	property p_rel;
		!chain_select_out_n |-> ##[1:64] chip_select_n;
	endproperty
	a_rel: assert property (p_rel) else $error("memory not released");
	// three high cycles keep the clock under its ceiling
	property p_clk;
		$rose(config_clock) |-> config_clock [*3];
	endproperty
	a_clk: assert property (p_clk) else $error("clock high too short");
	cover property ($fell(chain_select_out_n));
	cover property (busy && !chip_select_n);
	cover property (data_oe == 8'hFF);
endmodule
`default_nettype wire

/* verification/config_prom_read_port_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module config_prom_read_port_tb_top;
	typedef struct {
		logic w;
		logic p;
		int term;
		int loc;
	} row_t;
	// serial, ignored strap, one-byte image, overrun past the end
	row_t rows[6] = '{'{1'b0, 1'b0, 15, 16}, '{1'b0, 1'b1, 7, 8},
		'{1'b1, 1'b0, 23, 24}, '{1'b1, 1'b1, 4, 5},
		'{1'b1, 1'b1, 0, 1}, '{1'b1, 1'b1, 2, 4}};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic prog_we = 1'b0;
	logic [7:0] prog_addr = 8'h00;
	logic [7:0] prog_wdata = 8'h00;
	logic wide = 1'b0;
	logic par = 1'b0;
	logic start = 1'b0;
	logic hold_req = 1'b0;
	logic [10:0] term = 11'h000;
	logic [10:0] loc = 11'h000;
	logic [7:0] rx_data;
	logic rx_valid, done, standby, past_end;
	logic [7:0] rx_q[$];
	int err_count = 0;
	int total_checks = 0;
	cfg_prom_if link();
	config_prom_read_port i_config_prom_read_port (.clk(clk), .rstn(rstn),
		.link(link), .prog_we(prog_we), .prog_addr(prog_addr),
		.prog_wdata(prog_wdata), .wide_variant(wide), .parallel_mode(par),
		.reset_active_low(1'b1), .busy_pulldown(1'b1),
		.terminal_count(term), .standby(standby), .past_end(past_end));
	config_loader i_config_loader (.clk(clk), .rstn(rstn), .link(link),
		.start(start), .parallel_mode(par & wide), .location_count(loc),
		.hold_req(hold_req), .rx_data(rx_data), .rx_valid(rx_valid),
		.loading(), .done(done));
	cfg_link_props i_cfg_link_props (.clk(clk), .rstn(rstn),
		.config_clock(link.config_clock), .chip_select_n(link.chip_select_n),
		.reset_gate(link.reset_gate), .busy(link.busy),
		.data_out(link.data_out), .data_oe(link.data_oe),
		.chain_select_out_n(link.chain_select_out_n));
	initial begin
		forever #5 clk = ~clk;
	end
	// every delivered byte, in arrival order
	always @(posedge clk) begin
		if (rx_valid === 1'b1) begin
			rx_q.push_back(rx_data);
		end
	end
	function automatic logic [7:0] pat(input int a);
		return 8'(a * 59 + 17);
	endfunction
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// straps change only while the loader sits idle or done
	task automatic kick(input logic w, input logic p, input int t, input int l);
		@(posedge clk);
		wide <= w;
		par <= p;
		term <= 11'(t);
		loc <= 11'(l);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		rx_q.delete();
	endtask
	task automatic run_load(input row_t r, input bit hold);
		int n;
		int u;
		logic seen;
		kick(r.w, r.p, r.term, r.loc);
		if (hold) begin
			repeat (20) @(posedge clk);
			hold_req <= 1'b1;
			repeat (30) @(posedge clk);
			hold_req <= 1'b0;
		end
		@(negedge clk);
		n = 0;
		seen = 1'b0;
		// the end flag only stands until the loader deselects
		while (done !== 1'b1 && n < 3000) begin
			@(negedge clk);
			seen = seen | past_end;
			n++;
		end
		@(negedge clk);
		check1(done, 1'b1);
		check1(seen, 1'b1);
		check1(past_end, 1'b0);
		check1(standby, 1'b1);
		check1(link.chain_select_out_n, 1'b1);
		n = (r.p && r.w) ? r.loc : r.loc / 8;
		check8(8'(rx_q.size()), 8'(n));
		for (int i = 0; i < rx_q.size(); i++) begin
			u = (r.p && r.w) ? i : 8 * i + 7;
			check8(rx_q[i], u <= r.term ? pat(i) : 8'h00);
		end
	endtask
	initial begin
		#200000;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		// fill the array before any load
		for (int a = 0; a < 32; a++) begin
			@(posedge clk);
			prog_we <= 1'b1;
			prog_addr <= 8'(a);
			prog_wdata <= pat(a);
		end
		@(posedge clk);
		prog_we <= 1'b0;
		foreach (rows[k]) begin
			run_load(rows[k], 1'b0);
		end
		// a hold mid-stream must neither drop nor repeat a byte
		run_load('{1'b1, 1'b1, 9, 10}, 1'b1);
		// reset in mid-run once the end flag has set
		kick(1'b1, 1'b1, 0, 8);
		repeat (30) @(negedge clk);
		check1(past_end, 1'b1);
		@(posedge clk);
		rstn <= 1'b0;
		@(negedge clk);
		check1(past_end, 1'b0);
		check1(standby, 1'b1);
		@(posedge clk);
		rstn <= 1'b1;
		run_load(rows[3], 1'b0);
		complete_run();
	end
endmodule
`default_nettype wire
